// ### verilog/tcco_pkg.sv
// Package for the capture and clock-out timer: constants and carrier types
// Notes on behaviour
// - 16-bit counter, timer or event counter
// - capture, auto-reload, baud-rate modes from control bits
// - capture mode without edges sets overflow flag
// - overflow flag requests interrupt when enabled
// - trigger falling edge captures count bytes
// - trigger edge sets event flag outside up/down use, same interrupt unless down-count bit set
// - no reload in capture mode
// - counter keeps counting after capture
// - clock pin is count input or clock output
// - output frequency is osc over n(65536-reload)
// - capture pair forms reload, high byte upper
// - no interrupt from roll-overs in clock-out mode
// - baud and clock-out share one roll-over rate
// - control register layout, resets to zero
// - mode register clock-out bit1, down-count bit0
// - trigger edge ignored when disabled, level still sets up/down direction; when clocking serial it only sets event flag
package tcco_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Control register, bit 7 down to bit 0
  typedef struct packed {
    logic overflow_flag;           // Bit 7
    logic external_event_flag;     // Bit 6
    logic rx_clock_select;         // Bit 5
    logic transmit_clock_select;   // Bit 4
    logic external_edge_enable;    // Bit 3
    logic run_control;             // Bit 2
    logic count_source_select;     // Bit 1
    logic capture_reload_select;   // Bit 0
  } tcco_ctrl_t;

  // Mode register, defined low bits only
  typedef struct packed {
    logic clock_out_enable;        // Bit 1
    logic down_count_enable;       // Bit 0
  } tcco_mode_t;

  // Software write strobes with one shared data byte
  typedef struct packed {
    logic       ctrl_we;           // Control register
    logic       mode_we;           // Mode register
    logic       cnt_lo_we;         // Count low byte
    logic       cnt_hi_we;         // Count high byte
    logic       cap_lo_we;         // Capture low register
    logic       cap_hi_we;         // Capture high register
    logic [7:0] data;              // Write data
  } tcco_wr_t;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam tcco_ctrl_t CTRL_RESET  = 8'h00;
  localparam tcco_mode_t MODE_RESET  = 2'h0;
  localparam logic [15:0] CNT_RESET  = 16'h0000;
  localparam logic [15:0] CAP_RESET  = 16'h0000;
  localparam logic [15:0] COUNT_MAX  = 16'hFFFF;

  // Oscillator clocks per machine cycle
  localparam int MC_CLKS_6  = 6;
  localparam int MC_CLKS_12 = 12;
  localparam logic [3:0] MC_LAST_6  = 4'(MC_CLKS_6 - 1);
  localparam logic [3:0] MC_LAST_12 = 4'(MC_CLKS_12 - 1);

  // Clock-out divisor n; counter steps every n/2 clocks, pin toggles on roll
  localparam int CLKOUT_N_6  = 2;
  localparam int CLKOUT_N_12 = 4;
  localparam int FAST_DIV_6  = CLKOUT_N_6 / 2;
  localparam int FAST_DIV_12 = CLKOUT_N_12 / 2;

endpackage

// ### verilog/tcco_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module tcco_pin_sync
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      level
);
  import tcco_pkg::*;

  logic s1_reg, s2_reg, s3_reg, lvl_reg;   // Sync chain and filtered level
  logic s1_next, s2_next, s3_next, lvl_next;

  ////////////////////////////////////////////////////////////////////////////
  // Next values: a change counts only when stages two and three agree
  always_comb
  begin
    s1_next  = pin;
    s2_next  = s1_reg;
    s3_next  = s2_reg;
    lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
  end

  // Registers; idle level of a pin is high
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1_reg  <= 1'b1;
      s2_reg  <= 1'b1;
      s3_reg  <= 1'b1;
      lvl_reg <= 1'b1;
    end
    else
    begin
      s1_reg  <= s1_next;
      s2_reg  <= s2_next;
      s3_reg  <= s3_next;
      lvl_reg <= lvl_next;
    end
  end

  assign level = lvl_reg;

endmodule

// ### verilog/tcco_timer.sv
// Sixteen-bit timer with capture, reload, baud and clock-out modes
`timescale 1ns/1ps
module tcco_timer
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             twelve_clock_mode,
  input  wire logic             timer_int_enable,
  input  wire tcco_pkg::tcco_wr_t sw_wr,
  input  wire logic             ext_trigger_pin,
  input  wire logic             clock_out_pin_i,
  output logic                  clock_out_pin_o,
  output logic                  clock_out_pin_oe,
  output tcco_pkg::tcco_ctrl_t  timer_control_reg,
  output tcco_pkg::tcco_mode_t  timer_mode_reg,
  output logic [7:0]            count_low_byte,
  output logic [7:0]            count_high_byte,
  output logic [7:0]            capture_low_reg,
  output logic [7:0]            capture_high_reg,
  output logic                  timer_irq,
  output logic                  baud_tick
);
  import tcco_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  tcco_ctrl_t  ctrl_reg, ctrl_next;         // Control register
  tcco_mode_t  mode_reg, mode_next;         // Mode register
  logic [15:0] count_reg, count_next;       // Counter pair
  logic [15:0] cap_reg, cap_next;           // Capture / reload pair
  logic [3:0]  pres_reg, pres_next;         // Machine-cycle prescaler
  logic        half_reg, half_next;         // Half-rate toggle
  logic        trig_prev_reg, trig_prev_next;  // Trigger sample
  logic        cpin_prev_reg, cpin_prev_next;  // Count pin sample
  logic        clk_out_reg, clk_out_next;   // Clock-out level
  logic        oe_reg, oe_next;             // Clock-out drive enable
  logic        irq_reg, irq_next;           // Interrupt request
  logic        baud_reg, baud_next;         // Serial roll-over pulse

  // Filtered pin levels
  logic        trig_lvl;
  logic        cpin_lvl;

  // Decoded conditions
  logic        mtick;          // Last clock of a machine cycle
  logic        fast_tick;      // Step in clock-out or baud mode
  logic        serial_mode;    // Timer clocks the serial port
  logic        clkout_mode;    // Clock output active
  logic        fast_mode;      // Either of the two above
  logic        reload_mode;    // Reload on roll-over
  logic        updown;         // Direction taken from trigger pin
  logic        count_down;     // Counting down this cycle
  logic        trig_fall;      // Qualified trigger falling edge
  logic        cpin_fall;      // Count pin falling edge
  logic        step;           // Counter advances
  logic        roll_up;        // Overflow from all ones
  logic        roll_dn;        // Underflow at reload value
  logic        roll;           // Any roll-over
  logic        ext_evt;        // Trigger event sets the flag
  logic        ext_act;        // Trigger event acts on counter

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  tcco_pin_sync u_trig_sync
  (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   (ext_trigger_pin),
    .level (trig_lvl)
  );

  tcco_pin_sync u_cpin_sync
  (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   (clock_out_pin_i),
    .level (cpin_lvl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode and event detection
  always_comb
  begin
    // Machine cycle is 6 or 12 oscillator clocks
    mtick = pres_reg == (twelve_clock_mode ? MC_LAST_12 : MC_LAST_6);
    // Fast rate gives osc over n times the span at the pin
    fast_tick = (twelve_clock_mode ? FAST_DIV_12 : FAST_DIV_6) == 1
              ? 1'b1 : half_reg;
    serial_mode = ctrl_reg.rx_clock_select
                | ctrl_reg.transmit_clock_select;
    clkout_mode = mode_reg.clock_out_enable
                & ~ctrl_reg.count_source_select;
    fast_mode   = serial_mode | clkout_mode;
    // Serial or clock-out use forces reload whatever the select bit says
    reload_mode = ~ctrl_reg.capture_reload_select | fast_mode;
    updown      = reload_mode & ~fast_mode
                & mode_reg.down_count_enable;
    count_down  = updown & ~trig_lvl;
    // Pins are looked at on machine ticks only
    trig_fall   = mtick & trig_prev_reg & ~trig_lvl;
    cpin_fall   = mtick & cpin_prev_reg & ~cpin_lvl;
    // Timer counts machine cycles or fast ticks, counter counts pin edges
    if (!ctrl_reg.run_control)
      step = 1'b0;
    else if (ctrl_reg.count_source_select)
      step = cpin_fall;
    else if (fast_mode)
      step = fast_tick;
    else
      step = mtick;
    roll_up = step & ~count_down & (count_reg == COUNT_MAX);
    roll_dn = step & count_down & (count_reg == cap_reg);
    roll    = roll_up | roll_dn;
    // In up/down use the pin is a direction, not an event
    ext_evt = ctrl_reg.external_edge_enable & trig_fall & ~updown;
    ext_act = ext_evt & ~serial_mode;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter and capture pair next values
  always_comb
  begin
    count_next = count_reg;
    cap_next   = cap_reg;
    if (roll_up)
    begin
      // Capture mode wraps to zero with no reload
      count_next = reload_mode ? cap_reg : CNT_RESET;
    end
    else if (roll_dn)
      count_next = COUNT_MAX;
    else if (step)
      count_next = count_down ? count_reg - 16'h0001
                              : count_reg + 16'h0001;
    // Trigger edge: reload in reload mode, capture otherwise
    if (ext_act && reload_mode)
      count_next = cap_reg;
    if (ext_act && !reload_mode)
      cap_next = count_reg;
    // Software writes take the byte lanes they name
    if (sw_wr.cnt_lo_we)
      count_next[7:0] = sw_wr.data;
    if (sw_wr.cnt_hi_we)
      count_next[15:8] = sw_wr.data;
    if (sw_wr.cap_lo_we)
      cap_next[7:0] = sw_wr.data;
    if (sw_wr.cap_hi_we)
      cap_next[15:8] = sw_wr.data;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control, mode, flags and pin outputs next values
  always_comb
  begin
    ctrl_next = ctrl_reg;
    mode_next = mode_reg;
    if (sw_wr.ctrl_we)
      ctrl_next = tcco_ctrl_t'(sw_wr.data);
    if (sw_wr.mode_we)
      mode_next = tcco_mode_t'(sw_wr.data[1:0]);
    // Roll-overs in clock-out or baud use never set the flag
    if (roll && !fast_mode)
      ctrl_next.overflow_flag = 1'b1;
    // Flag set on trigger events, toggled on up/down rolls; clearing is otherwise software's job
    if (ext_evt)
      ctrl_next.external_event_flag = 1'b1;
    else if (roll && updown)
      ctrl_next.external_event_flag = ~ctrl_reg.external_event_flag;
    // Event flag does not interrupt in up/down use
    irq_next = timer_int_enable
             & (ctrl_next.overflow_flag
                | (ctrl_next.external_event_flag
                   & ~mode_next.down_count_enable));
    // Pin toggles each roll-over for a 50% duty clock
    clk_out_next = (clkout_mode && roll) ? ~clk_out_reg
                                         : clk_out_reg;
    oe_next      = clkout_mode;
    baud_next    = roll & serial_mode;
    pres_next    = mtick ? 4'h0 : pres_reg + 4'h1;
    half_next    = ~half_reg;
    trig_prev_next = mtick ? trig_lvl : trig_prev_reg;
    cpin_prev_next = mtick ? cpin_lvl : cpin_prev_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctrl_reg      <= CTRL_RESET;
      mode_reg      <= MODE_RESET;
      count_reg     <= CNT_RESET;
      cap_reg       <= CAP_RESET;
      pres_reg      <= 4'h0;
      half_reg      <= 1'b0;
      trig_prev_reg <= 1'b1;
      cpin_prev_reg <= 1'b1;
      clk_out_reg   <= 1'b1;
      oe_reg        <= 1'b0;
      irq_reg       <= 1'b0;
      baud_reg      <= 1'b0;
    end
    else
    begin
      ctrl_reg      <= ctrl_next;
      mode_reg      <= mode_next;
      count_reg     <= count_next;
      cap_reg       <= cap_next;
      pres_reg      <= pres_next;
      half_reg      <= half_next;
      trig_prev_reg <= trig_prev_next;
      cpin_prev_reg <= cpin_prev_next;
      clk_out_reg   <= clk_out_next;
      oe_reg        <= oe_next;
      irq_reg       <= irq_next;
      baud_reg      <= baud_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from registers
  assign timer_control_reg = ctrl_reg;
  assign timer_mode_reg    = mode_reg;
  assign count_low_byte    = count_reg[7:0];
  assign count_high_byte   = count_reg[15:8];
  assign capture_low_reg   = cap_reg[7:0];
  assign capture_high_reg  = cap_reg[15:8];
  assign clock_out_pin_o   = clk_out_reg;
  assign clock_out_pin_oe  = oe_reg;
  assign timer_irq         = irq_reg;
  assign baud_tick         = baud_reg;

endmodule

// ### dv/tcco_timer_props.sv
// Concurrent checks on the ports of the capture and clock-out timer
`timescale 1ns/1ps
module tcco_timer_props
(
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire logic                 twelve_clock_mode,
  input wire logic                 timer_int_enable,
  input wire tcco_pkg::tcco_wr_t   sw_wr,
  input wire logic                 clock_out_pin_o,
  input wire logic                 clock_out_pin_oe,
  input wire tcco_pkg::tcco_ctrl_t timer_control_reg,
  input wire tcco_pkg::tcco_mode_t timer_mode_reg,
  input wire logic [7:0]           count_low_byte,
  input wire logic [7:0]           count_high_byte,
  input wire logic [7:0]           capture_low_reg,
  input wire logic [7:0]           capture_high_reg,
  input wire logic                 timer_irq,
  input wire logic                 baud_tick
);
  import tcco_pkg::*;
  tcco_ctrl_t  ctl;   // Short alias of the control register
  logic [15:0] cnt;   // Count pair
  logic [15:0] cap;   // Capture pair
  logic        capm;  // Capture mode, no serial or clock-out use
  logic        cwe;   // Software count write
  logic        pwe;   // Software capture write
  logic        tmr6;  // Timer source, six clocks a step
  assign ctl  = timer_control_reg;
  assign cnt  = {count_high_byte, count_low_byte};
  assign cap  = {capture_high_reg, capture_low_reg};
  assign capm = ctl.capture_reload_select & ~ctl.rx_clock_select
              & ~ctl.transmit_clock_select & ~timer_mode_reg.clock_out_enable;
  assign cwe  = sw_wr.cnt_lo_we | sw_wr.cnt_hi_we;
  assign pwe  = sw_wr.cap_lo_we | sw_wr.cap_hi_we;
  assign tmr6 = capm & ctl.run_control & ~ctl.count_source_select
              & ~twelve_clock_mode;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  // Steps are plus one, also through the roll, so no reload sneaks in
  property p_step;
    $past(capm && !cwe) && $changed(cnt) |-> cnt == $past(cnt) + 16'h0001;
  endproperty
  a_step: assert property (p_step)
    else $error("capture mode count did not step by one");
  // Six clocks between timer steps, a capture does not disturb it
  property p_gap;
    $past(tmr6 && !cwe) && $changed(cnt)
      |=> ($stable(cnt) || $past(!tmr6 || cwe))[*5];
  endproperty
  a_gap: assert property (p_gap)
    else $error("timer stepped early");
  property p_ovf;
    capm && !cwe && cnt == COUNT_MAX ##1 cnt == CNT_RESET
      |-> ctl.overflow_flag;
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("roll without overflow flag");
  // Request is registered together with the flags it follows
  property p_irq;
    timer_irq == ($past(timer_int_enable) && (ctl.overflow_flag
      || (ctl.external_event_flag && !timer_mode_reg.down_count_enable)));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt request wrong");
  // Pair takes the count seen before the capturing edge
  property p_cap;
    $past(capm && ctl.external_edge_enable && !pwe) && $changed(cap)
      |-> cap == $past(cnt) && ctl.external_event_flag;
  endproperty
  a_cap: assert property (p_cap)
    else $error("capture value or flag wrong");
  property p_ign;
    $past((capm && !ctl.external_edge_enable || ctl.rx_clock_select
      || ctl.transmit_clock_select) && !pwe) |-> $stable(cap);
  endproperty
  a_ign: assert property (p_ign)
    else $error("capture pair changed while ignored");
  property p_noovf;
    $past(timer_mode_reg.clock_out_enable && !ctl.count_source_select
      && !sw_wr.ctrl_we) |-> !$rose(ctl.overflow_flag);
  endproperty
  a_noovf: assert property (p_noovf)
    else $error("overflow flag in clock-out mode");
  // Pin toggles only on a reload roll; baud pulse lands with it when the transmit clock is selected
  property p_tog;
    clock_out_pin_oe && $changed(clock_out_pin_o) |-> cnt == cap
      && (baud_tick || !$past(ctl.transmit_clock_select));
  endproperty
  a_tog: assert property (p_tog)
    else $error("clock pin toggled off the roll");
endmodule

bind tcco_timer tcco_timer_props tcco_timer_props_i
(
  .clk(clk), .rst_n(rst_n), .twelve_clock_mode(twelve_clock_mode),
  .timer_int_enable(timer_int_enable), .sw_wr(sw_wr),
  .clock_out_pin_o(clock_out_pin_o), .clock_out_pin_oe(clock_out_pin_oe),
  .timer_control_reg(timer_control_reg), .timer_mode_reg(timer_mode_reg),
  .count_low_byte(count_low_byte), .count_high_byte(count_high_byte),
  .capture_low_reg(capture_low_reg), .capture_high_reg(capture_high_reg),
  .timer_irq(timer_irq), .baud_tick(baud_tick)
);

// ### dv/tcco_pin_model.sv
// Model of the trigger source and of the load on the clock pin
`timescale 1ns/1ps
module tcco_pin_model
(
  input  wire logic clk,
  input  wire logic clock_out_pin_o,
  input  wire logic clock_out_pin_oe,
  output logic      ext_trigger_pin,
  output logic      clock_out_pin_i
);
  logic src_lvl;  // External count source, idles high
  initial
  begin
    ext_trigger_pin = 1'b1;
    src_lvl = 1'b1;
  end
  // Timer wins the pin while it drives, else the outside source
  assign clock_out_pin_i = clock_out_pin_oe ? clock_out_pin_o : src_lvl;
  // Falling trigger edge, held low for hold cycles
  task automatic trig_fall(input int hold);
    @(posedge clk);
    #2;
    ext_trigger_pin = 1'b0;
    repeat (hold) @(posedge clk);
    #2;
    ext_trigger_pin = 1'b1;
  endtask
  // Slow pulses; each level must outlast a machine cycle
  task automatic src_pulses(input int n, input int w);
    repeat (n)
    begin
      repeat (w) @(posedge clk);
      #2;
      src_lvl = 1'b0;
      repeat (w) @(posedge clk);
      #2;
      src_lvl = 1'b1;
    end
  endtask
endmodule

// ### dv/tb_top.sv
// Self-checking testbench for the capture and clock-out timer
`timescale 1ns/1ps
module tb_top;
  import tcco_pkg::*;
  logic       clk, rst_n, twelve, int_en;  // Clock, reset, mode, enable
  tcco_wr_t   sw_wr;                       // Software write strobes
  logic       trig, pin_i, pin_o, pin_oe;  // Pin side
  tcco_ctrl_t ctl;                         // Control register
  tcco_mode_t md;                          // Mode register
  logic [7:0] clo, chi, plo, phi;          // Count and capture bytes
  logic       irq, baud;                   // Interrupt, baud pulse
  int         error_cnt, n_tests, cyc;     // Counters
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  tcco_timer tcco_timer_i
  (
    .clk(clk), .rst_n(rst_n), .twelve_clock_mode(twelve),
    .timer_int_enable(int_en), .sw_wr(sw_wr), .ext_trigger_pin(trig),
    .clock_out_pin_i(pin_i), .clock_out_pin_o(pin_o),
    .clock_out_pin_oe(pin_oe), .timer_control_reg(ctl),
    .timer_mode_reg(md), .count_low_byte(clo), .count_high_byte(chi),
    .capture_low_reg(plo), .capture_high_reg(phi), .timer_irq(irq),
    .baud_tick(baud)
  );
  tcco_pin_model tcco_pin_model_i
  (
    .clk(clk), .clock_out_pin_o(pin_o), .clock_out_pin_oe(pin_oe),
    .ext_trigger_pin(trig), .clock_out_pin_i(pin_i)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // Strobe k: 0 ctrl, 1 mode, 2/3 count low/high, 4/5 capture low/high
  task automatic wr(input int k, input logic [7:0] d);
    tick();
    sw_wr = tcco_wr_t'({6'h20 >> k, d});
    tick();
    sw_wr = '0;
  endtask
  task automatic do_reset(input logic tw);
    tick();
    rst_n = 1'b0;
    twelve = tw;
    tick(12);
    rst_n = 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk(ctl, 16'h0000, "control reset");
    chk(md, 16'h0000, "mode reset");
    chk({chi, clo, phi, plo} == 32'h0, 16'h0001, "pairs reset");
    chk({pin_o, pin_oe, irq, baud}, 16'h0008, "outputs reset");
    wr(1, 8'hFF);
    chk(md, 16'h0003, "mode upper bits");
    wr(1, 8'h00);
    wr(4, 8'h34);
    wr(5, 8'h12);
    chk({phi, plo}, 16'h1234, "capture pair");
  endtask
  task automatic t_timer();
    logic [15:0] c;
    int          k;
    int_en = 1'b1;
    wr(2, 8'hF0);
    wr(3, 8'hFF);
    wr(0, 8'h05);
    for (int j = 0; j < 2; j++)
    begin
      c = {chi, clo};
      for (k = 0; k < 20 && {chi, clo} === c; k++) tick();
    end
    chk(16'(k), 16'(MC_CLKS_6), "step spacing");
    for (k = 0; k < 200 && ctl.overflow_flag !== 1'b1; k++) tick();
    chk(ctl.overflow_flag, 1'b1, "overflow flag");
    chk(chi, 8'h00, "no reload");
    tick();
    chk(irq, 1'b1, "overflow irq");
    wr(0, 8'h05);
    tick();
    chk({ctl.overflow_flag, irq}, 16'h0000, "flag cleared");
  endtask
  task automatic t_capture();
    logic [15:0] c;
    tcco_pin_model_i.trig_fall(20);
    chk(ctl.external_event_flag, 1'b0, "edge ignored");
    chk({phi, plo}, 16'h1234, "pair kept");
    wr(0, 8'h0D);
    c = {chi, clo};
    tcco_pin_model_i.trig_fall(20);
    tick(12);
    chk(ctl.external_event_flag, 1'b1, "event flag");
    chk({phi, plo} >= c && {phi, plo} < {chi, clo}, 16'h0001,
        "capture");
    chk(irq, 1'b1, "event irq");
    wr(0, 8'h05);
    chk(ctl.external_event_flag, 1'b0, "software clear");
  endtask
  task automatic t_counter();
    wr(0, 8'h00);
    wr(2, 8'h00);
    wr(3, 8'h00);
    wr(0, 8'h07);
    tcco_pin_model_i.src_pulses(5, 15);
    chk({chi, clo}, 16'h0005, "event count");
  endtask
  task automatic t_clkout(input logic tw);
    logic p;
    int   k;
    int   e;
    e = (tw ? CLKOUT_N_12 : CLKOUT_N_6) * (65536 - 16'hFFF0) / 2;
    do_reset(tw);
    wr(2, 8'hF0);
    wr(3, 8'hFF);
    wr(4, 8'hF0);
    wr(5, 8'hFF);
    wr(0, 8'h14);
    wr(1, 8'h02);
    tick();
    chk(pin_oe, 1'b1, "pin driven");
    for (int j = 0; j < 2; j++)
    begin
      p = pin_o;
      for (k = 0; k < 100 && pin_o === p; k++) tick();
      chk(baud, 1'b1, "baud at toggle");
    end
    chk(16'(k), 16'(e), "half period");
    chk(ctl.overflow_flag, 1'b0, "no overflow");
    chk(irq, 1'b0, "no roll irq");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Hang guard, far above the under one thousand cycles the tests need
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      $display("BAD %0t run did not finish", $time);
      conclude();
    end
  end
  initial
  begin
    {rst_n, twelve, int_en, sw_wr, error_cnt, n_tests, cyc} = '0;
    do_reset(1'b0);
    t_reset();
    $display("test reset done");
    t_timer();
    $display("test timer done");
    t_capture();
    $display("test capture done");
    t_counter();
    $display("test counter done");
    t_clkout(1'b0);
    $display("test clock-out six done");
    t_clkout(1'b1);
    $display("test clock-out twelve done");
    conclude();
  end
endmodule
